// File: src/csfd_pkg.sv
// Shared constants, opcodes and states of the status flag datapath
package csfd_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  // Processor status word bit positions
  localparam int PS_C = 0;
  localparam int PS_Z = 1;
  localparam int PS_I = 2;
  localparam int PS_D = 3;
  localparam int PS_B = 4;
  localparam int PS_T = 5;
  localparam int PS_V = 6;
  localparam int PS_N = 7;
  localparam logic [7:0] PS_RESET = 8'h04;
  localparam logic [7:0] SP_RESET = 8'hff;
  localparam logic [7:0] STACK_PAGE = 8'h01;
  // Register port indices
  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_INDEX_X = 3'h1;
  localparam logic [2:0] REG_INDEX_Y = 3'h2;
  localparam logic [2:0] REG_STACK = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;

  typedef enum logic [4:0] {
    OP_CARRY_ADD = 5'h00, OP_BORROW_SUB = 5'h01, OP_CONJ = 5'h02, OP_XOR = 5'h03,
    OP_IOR = 5'h04, OP_BIT_CLEAR = 5'h05, OP_BIT_SET = 5'h06, OP_SHL = 5'h07,
    OP_SHR = 5'h08, OP_ROT_LEFT = 5'h09, OP_ROT_RIGHT = 5'h0a, OP_NIB_ROT = 5'h0b,
    OP_COUNT_UP = 5'h0c, OP_COUNT_DOWN = 5'h0d, OP_INVERT = 5'h0e, OP_STATUS_PUSH = 5'h0f,
    OP_STATUS_PULL = 5'h10, OP_PRODUCT = 5'h11, OP_QUOTIENT = 5'h12, OP_JUMP_IND = 5'h13,
    OP_DEC_SET = 5'h14, OP_DEC_CLEAR = 5'h15, OP_CARRY_SET = 5'h16, OP_CARRY_CLEAR = 5'h17,
    OP_XMODE_SET = 5'h18, OP_XMODE_CLEAR = 5'h19, OP_IRQ_OFF = 5'h1a, OP_IRQ_ON = 5'h1b
  } csfd_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_READ = 3'b001, ST_EXEC = 3'b010, ST_WRITE = 3'b011,
    ST_HI_READ = 3'b100, ST_HI_EXEC = 3'b101
  } csfd_state_t;

  // Always read-modify-write on memory
  function automatic logic csfd_is_rmw(input csfd_op_t op);
    return op inside {OP_BIT_CLEAR, OP_BIT_SET, OP_SHL, OP_SHR, OP_ROT_LEFT,
      OP_ROT_RIGHT, OP_NIB_ROT, OP_COUNT_UP, OP_COUNT_DOWN, OP_INVERT};
  endfunction

  // Accumulator operations that move to memory in index-memory mode
  function automatic logic csfd_is_acc_op(input csfd_op_t op);
    return op inside {OP_CARRY_ADD, OP_BORROW_SUB, OP_CONJ, OP_XOR, OP_IOR};
  endfunction

  function automatic logic [7:0] csfd_bcd_val(input logic [7:0] b);
    return 8'(({4'h0, b[7:4]} * 8'd10) + {4'h0, b[3:0]});
  endfunction
endpackage

// File: src/csfd_adder.sv
// Binary and packed decimal add and subtract
`timescale 1ns/1ns
module csfd_adder (
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  input wire logic i_carry,
  input wire logic i_sub,
  input wire logic i_decimal,
  output logic [7:0] o_result,
  output logic o_carry,
  output logic o_overflow
);
  logic [7:0] b_eff;
  logic [8:0] bin_sum;
  logic [4:0] lo_add;
  logic [4:0] lo_fix;
  logic [4:0] hi_add;
  logic [4:0] hi_fix;
  logic [4:0] lo_sub;
  logic [4:0] hi_sub;
  logic [7:0] dec_add;
  logic [7:0] dec_sub;
  logic dec_add_c;
  logic dec_sub_c;

  assign b_eff = i_sub ? ~i_b : i_b;
  assign bin_sum = {1'b0, i_a} + {1'b0, b_eff} + {8'h00, i_carry};
  assign o_overflow = (i_a[7] == b_eff[7]) && (bin_sum[7] != i_a[7]);
  // Decimal add: each nibble above nine gets six added
  assign lo_add = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_carry};
  assign lo_fix = (lo_add > 5'h09) ? 5'(lo_add + 5'h06) : lo_add;
  assign hi_add = {1'b0, i_a[7:4]} + {1'b0, i_b[7:4]} + {4'h0, lo_fix[4]};
  assign hi_fix = (hi_add > 5'h09) ? 5'(hi_add + 5'h06) : hi_add;
  assign dec_add = {hi_fix[3:0], lo_fix[3:0]};
  assign dec_add_c = hi_fix[4];
  // Decimal subtract: a borrowing nibble gets six taken off
  assign lo_sub = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, ~i_carry};
  assign hi_sub = {1'b0, i_a[7:4]} - {1'b0, i_b[7:4]} - {4'h0, lo_sub[4]};
  assign dec_sub = {(hi_sub[4] ? 4'(hi_sub[3:0] - 4'h6) : hi_sub[3:0]),
                    (lo_sub[4] ? 4'(lo_sub[3:0] - 4'h6) : lo_sub[3:0])};
  assign dec_sub_c = ~hi_sub[4];
  assign o_result = !i_decimal ? bin_sum[7:0] : (i_sub ? dec_sub : dec_add);
  assign o_carry = !i_decimal ? bin_sum[8] : (i_sub ? dec_sub_c : dec_add_c);
endmodule // csfd_adder

// File: src/csfd_muldiv.sv
// Plain binary product and quotient
`timescale 1ns/1ns
module csfd_muldiv (
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_m,
  output logic [15:0] o_product,
  output logic [7:0] o_quotient,
  output logic [7:0] o_remainder
);
  assign o_product = {8'h00, i_a} * {8'h00, i_m};
  // Divide by zero gives all ones and keeps the dividend as remainder
  assign o_quotient = (i_m == 8'h00) ? 8'hff : 8'(i_a / i_m);
  assign o_remainder = (i_m == 8'h00) ? i_a : 8'(i_a % i_m);
endmodule // csfd_muldiv

// File: src/csfd_core.sv
// Status word, arithmetic datapath and read-modify-write sequencer
// Operation
// RULE_01 - Reset sets interrupt disable flag only
// RULE_02 - Status push leaves word at S+1
// RULE_03 - Decimal results only for add and subtract
// RULE_04 - Decimal N, V, Z flags carry no meaning
// RULE_05 - Decimal carry set on carry, cleared on borrow
// RULE_06 - Multiply and divide ignore mode flags
// RULE_07 - Multiply and divide keep status word
// RULE_08 - Read-modify-write reads, modifies, writes same address
// RULE_09 - Bit, shift, rotate, count, invert use read-modify-write
// RULE_10 - Index-memory mode makes accumulator ops read-modify-write
// RULE_11 - Unreadable targets still read, modified, written back
// RULE_12 - Software avoids pointers on page last byte
// RULE_13 - Pointer high fetch wraps within page
// RULE_14 - Index-memory mode targets memory, not accumulator
`timescale 1ns/1ns
module csfd_core (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire csfd_pkg::csfd_op_t i_cmd_op,
  input wire logic [csfd_pkg::ADDR_W-1:0] i_cmd_addr,
  input wire logic [2:0] i_cmd_bit,
  output logic o_cmd_ready,
  output logic o_cmd_done,
  output logic [csfd_pkg::ADDR_W-1:0] o_mem_addr,
  output logic [csfd_pkg::DATA_W-1:0] o_mem_wdata,
  output logic o_mem_we,
  output logic o_mem_re,
  input wire logic [csfd_pkg::DATA_W-1:0] i_mem_rdata,
  input wire logic [2:0] i_reg_addr,
  input wire logic [csfd_pkg::DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_we,
  input wire logic i_reg_re,
  output logic [csfd_pkg::DATA_W-1:0] o_reg_rdata,
  output logic [csfd_pkg::DATA_W-1:0] o_status,
  output logic [csfd_pkg::ADDR_W-1:0] o_jump_target
);
  import csfd_pkg::*;

  csfd_state_t state_reg, state_next;
  csfd_op_t op_reg;
  logic [7:0] acc_reg, x_reg, y_reg, sp_reg, ps_reg;
  logic [15:0] addr_reg;
  logic [2:0] bit_reg;
  logic [7:0] ptr_lo_reg;
  logic [7:0] acc_next, y_next, sp_next, ps_next;
  logic rmw_reg;

  // Command decode
  wire accept = i_cmd_valid && o_cmd_ready;
  wire t_flag = ps_reg[PS_T];
  wire d_flag = ps_reg[PS_D];
  wire cmd_rmw = csfd_is_rmw(i_cmd_op) || (t_flag && csfd_is_acc_op(i_cmd_op)); // see RULE_09
  wire cmd_reads = cmd_rmw || csfd_is_acc_op(i_cmd_op) ||
                   (i_cmd_op inside {OP_STATUS_PULL, OP_PRODUCT, OP_QUOTIENT, OP_JUMP_IND});
  wire cmd_push = (i_cmd_op == OP_STATUS_PUSH);
  wire [7:0] sp_inc = 8'(sp_reg + 8'h01);
  wire [7:0] sp_dec = 8'(sp_reg - 8'h01);
  wire [15:0] stack_top = {STACK_PAGE, sp_reg};
  wire [15:0] stack_pull = {STACK_PAGE, sp_inc};
  wire [15:0] read_addr = (i_cmd_op == OP_STATUS_PULL) ? stack_pull : i_cmd_addr;
  // Pointer high byte wraps within the page
  wire [15:0] ptr_hi_addr = {addr_reg[15:8], 8'(addr_reg[7:0] + 8'h01)}; // see RULE_13
  wire [7:0] mem_val = i_mem_rdata;
  wire is_sub = (op_reg == OP_BORROW_SUB);
  // Index-memory mode swaps operands so memory is the destination
  wire [7:0] opnd_a = rmw_reg ? mem_val : acc_reg; // see RULE_14
  wire [7:0] opnd_b = rmw_reg ? acc_reg : mem_val;
  wire [7:0] bit_mask = 8'(8'h01 << bit_reg);

  logic [7:0] add_res;
  logic add_c;
  logic add_v;
  logic [15:0] prod;
  logic [7:0] quot;
  logic [7:0] rem;

  // Decimal mode reaches the adder only
  csfd_adder u_adder (
    .i_a(opnd_a),
    .i_b(opnd_b),
    .i_carry(ps_reg[PS_C]),
    .i_sub(is_sub),
    .i_decimal(d_flag), // see RULE_03
    .o_result(add_res),
    .o_carry(add_c),
    .o_overflow(add_v)
  );

  // No mode flag enters the multiplier or divider
  csfd_muldiv u_muldiv (
    .i_a(acc_reg), // see RULE_06
    .i_m(mem_val),
    .o_product(prod),
    .o_quotient(quot),
    .o_remainder(rem)
  );

  // Result byte and carry out of the modify step
  logic [7:0] res;
  logic res_c;
  always_comb begin
    res = add_res;
    res_c = ps_reg[PS_C];
    case (op_reg)
      OP_CARRY_ADD, OP_BORROW_SUB: begin
        res = add_res;
        res_c = add_c; // see RULE_05
      end
      OP_CONJ: res = opnd_a & opnd_b;
      OP_XOR: res = opnd_a ^ opnd_b;
      OP_IOR: res = opnd_a | opnd_b;
      OP_BIT_CLEAR: res = mem_val & ~bit_mask;
      OP_BIT_SET: res = mem_val | bit_mask;
      OP_SHL: begin
        res = {mem_val[6:0], 1'b0};
        res_c = mem_val[7];
      end
      OP_SHR: begin
        res = {1'b0, mem_val[7:1]};
        res_c = mem_val[0];
      end
      OP_ROT_LEFT: begin
        res = {mem_val[6:0], ps_reg[PS_C]};
        res_c = mem_val[7];
      end
      OP_ROT_RIGHT: begin
        res = {ps_reg[PS_C], mem_val[7:1]};
        res_c = mem_val[0];
      end
      OP_NIB_ROT: res = {mem_val[3:0], mem_val[7:4]};
      OP_COUNT_UP: res = 8'(mem_val + 8'h01);
      OP_COUNT_DOWN: res = 8'(mem_val - 8'h01);
      OP_INVERT: res = ~mem_val;
      default: res = mem_val;
    endcase
  end

  // Which flags the modify step rewrites
  wire upd_nz = csfd_is_acc_op(op_reg) || (op_reg inside {OP_SHL, OP_SHR, OP_ROT_LEFT,
                OP_ROT_RIGHT, OP_COUNT_UP, OP_COUNT_DOWN, OP_INVERT});
  wire upd_c = (op_reg inside {OP_CARRY_ADD, OP_BORROW_SUB, OP_SHL, OP_SHR, OP_ROT_LEFT,
                OP_ROT_RIGHT});
  // In decimal mode N and Z come from the corrected result, V from the binary sum, and they mean nothing
  wire upd_v = (op_reg inside {OP_CARRY_ADD, OP_BORROW_SUB}); // see RULE_04
  wire [7:0] ps_exec = {upd_nz ? res[7] : ps_reg[PS_N], upd_v ? add_v : ps_reg[PS_V],
                        ps_reg[5:2], upd_nz ? (res == 8'h00) : ps_reg[PS_Z],
                        upd_c ? res_c : ps_reg[PS_C]};
  wire in_exec = (state_reg == ST_EXEC);
  wire sw_status_we = i_reg_we && (i_reg_addr == REG_STATUS);

  // Next state and architectural register updates
  always_comb begin
    state_next = state_reg;
    acc_next = acc_reg;
    y_next = y_reg;
    sp_next = sp_reg;
    ps_next = ps_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          if (cmd_reads) begin
            state_next = ST_READ;
          end else if (cmd_push) begin
            state_next = ST_WRITE;
            sp_next = sp_dec; // see RULE_02
          end
          case (i_cmd_op)
            OP_STATUS_PULL: sp_next = sp_inc;
            OP_DEC_SET: ps_next[PS_D] = 1'b1;
            OP_DEC_CLEAR: ps_next[PS_D] = 1'b0;
            OP_CARRY_SET: ps_next[PS_C] = 1'b1;
            OP_CARRY_CLEAR: ps_next[PS_C] = 1'b0;
            OP_XMODE_SET: ps_next[PS_T] = 1'b1;
            OP_XMODE_CLEAR: ps_next[PS_T] = 1'b0;
            OP_IRQ_OFF: ps_next[PS_I] = 1'b1;
            OP_IRQ_ON: ps_next[PS_I] = 1'b0;
            default: ps_next = ps_reg;
          endcase
        end
      end
      ST_READ: state_next = ST_EXEC;
      ST_EXEC: begin
        // Unreadable targets get no special case: whatever came back is modified
        state_next = rmw_reg ? ST_WRITE : ST_IDLE; // see RULE_11
        case (op_reg)
          OP_STATUS_PULL: ps_next = mem_val;
          OP_PRODUCT: {y_next, acc_next} = prod; // see RULE_07
          OP_QUOTIENT: begin
            acc_next = quot;
            y_next = rem;
          end
          OP_JUMP_IND: state_next = ST_HI_READ;
          default: begin
            ps_next = ps_exec;
            if (!rmw_reg) begin
              acc_next = res; // see RULE_14
            end
          end
        endcase
      end
      ST_WRITE: state_next = ST_IDLE;
      ST_HI_READ: state_next = ST_HI_EXEC;
      ST_HI_EXEC: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // Sequencer and bus strobes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_CARRY_ADD;
      rmw_reg <= 1'b0;
      addr_reg <= 16'h0000;
      bit_reg <= 3'h0;
      ptr_lo_reg <= 8'h00;
      o_mem_addr <= 16'h0000;
      o_mem_wdata <= 8'h00;
      o_mem_we <= 1'b0;
      o_mem_re <= 1'b0;
      o_cmd_ready <= 1'b0;
      o_cmd_done <= 1'b0;
      o_jump_target <= 16'h0000;
    end else begin
      state_reg <= state_next;
      o_mem_we <= 1'b0;
      o_mem_re <= 1'b0;
      o_cmd_done <= 1'b0;
      o_cmd_ready <= (state_next == ST_IDLE);
      if (accept) begin
        op_reg <= i_cmd_op;
        rmw_reg <= cmd_rmw; // see RULE_10
        addr_reg <= read_addr;
        bit_reg <= i_cmd_bit;
        o_mem_addr <= cmd_push ? stack_top : read_addr;
        o_mem_wdata <= ps_reg;
        o_mem_re <= cmd_reads;
        o_mem_we <= cmd_push;
        o_cmd_done <= !cmd_reads && !cmd_push;
      end
      if (in_exec) begin
        if (rmw_reg) begin
          o_mem_addr <= addr_reg; // see RULE_08
          o_mem_wdata <= res;
          o_mem_we <= 1'b1;
        end else if (op_reg == OP_JUMP_IND) begin
          ptr_lo_reg <= mem_val;
          o_mem_addr <= ptr_hi_addr;
          o_mem_re <= 1'b1;
        end else begin
          o_cmd_done <= 1'b1;
        end
      end
      if (state_reg == ST_WRITE) begin
        o_cmd_done <= 1'b1;
      end
      if (state_reg == ST_HI_EXEC) begin
        o_jump_target <= {mem_val, ptr_lo_reg};
        o_cmd_done <= 1'b1;
      end
    end
  end

  // Architectural registers; the core wins over a software write in the same cycle when its update changes the register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acc_reg <= 8'h00;
      x_reg <= 8'h00;
      y_reg <= 8'h00;
      sp_reg <= SP_RESET;
      ps_reg <= PS_RESET; // see RULE_01
    end else begin
      acc_reg <= (i_reg_we && i_reg_addr == REG_ACC && acc_next == acc_reg) ?
                 i_reg_wdata : acc_next;
      y_reg <= (i_reg_we && i_reg_addr == REG_INDEX_Y && y_next == y_reg) ?
               i_reg_wdata : y_next;
      sp_reg <= (i_reg_we && i_reg_addr == REG_STACK && sp_next == sp_reg) ?
                i_reg_wdata : sp_next;
      ps_reg <= (sw_status_we && ps_next == ps_reg) ? i_reg_wdata : ps_next;
      if (i_reg_we && i_reg_addr == REG_INDEX_X) begin
        x_reg <= i_reg_wdata;
      end
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
      o_status <= PS_RESET;
    end else begin
      o_status <= ps_next;
      o_reg_rdata <= 8'h00;
      if (i_reg_re) begin
        case (i_reg_addr)
          REG_ACC: o_reg_rdata <= acc_reg;
          REG_INDEX_X: o_reg_rdata <= x_reg;
          REG_INDEX_Y: o_reg_rdata <= y_reg;
          REG_STACK: o_reg_rdata <= sp_reg;
          REG_STATUS: o_reg_rdata <= ps_reg;
          default: o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  sequence seq_rmw_read;
    o_mem_re ##1 (state_reg == ST_EXEC);
  endsequence
  sequence seq_rmw_write(logic [15:0] a);
    o_mem_we && (o_mem_addr == a);
  endsequence

  AST_RESET_IRQ_OFF: assert property (@(posedge i_clk) $fell(i_rst) |-> ps_reg[PS_I]) // see RULE_01
    else $error("interrupt disable not set after reset");
  AST_PUSH_SLOT: assert property (@(posedge i_clk) disable iff (i_rst) // see RULE_02
    (accept && cmd_push) |=> o_mem_we && (o_mem_addr == {STACK_PAGE, 8'(sp_reg + 8'h01)})
      && (o_mem_wdata == $past(ps_reg)))
    else $error("status push not at stack pointer plus one");
  AST_RMW_SEQUENCE: assert property (@(posedge i_clk) disable iff (i_rst) // see RULE_08
    (accept && cmd_rmw) |=> seq_rmw_read ##1 seq_rmw_write($past(read_addr, 3)))
    else $error("read-modify-write did not write back to the read address");
  AST_BINARY_ADD: assert property (@(posedge i_clk) disable iff (i_rst) // see RULE_03
    (in_exec && op_reg == OP_CARRY_ADD && !d_flag && !rmw_reg && !i_reg_we)
      |=> acc_reg == 8'($past(acc_reg) + $past(mem_val) + {7'h00, $past(ps_reg[PS_C])}))
    else $error("binary add result wrong with decimal flag clear");
  AST_DECIMAL_CARRY: assert property (@(posedge i_clk) disable iff (i_rst) // see RULE_05
    (in_exec && op_reg == OP_CARRY_ADD && d_flag && !sw_status_we)
      |=> ps_reg[PS_C] == ((9'(csfd_bcd_val($past(opnd_a))) + 9'(csfd_bcd_val($past(opnd_b)))
        + {8'h00, $past(ps_reg[PS_C])}) > 9'd99))
    else $error("decimal carry flag wrong");
  AST_MULDIV_KEEP_PS: assert property (@(posedge i_clk) disable iff (i_rst) // see RULE_07
    (in_exec && op_reg inside {OP_PRODUCT, OP_QUOTIENT} && !sw_status_we) |=> $stable(ps_reg))
    else $error("multiply or divide changed the status word");
  AST_PRODUCT_VALUE: assert property (@(posedge i_clk) disable iff (i_rst) // see RULE_06
    (in_exec && op_reg == OP_PRODUCT && !i_reg_we)
      |=> {y_reg, acc_reg} == ({8'h00, $past(acc_reg)} * {8'h00, $past(mem_val)}))
    else $error("product depends on mode flags");
  AST_ACC_MODE_NO_WRITE: assert property (@(posedge i_clk) disable iff (i_rst) // see RULE_10
    (accept && csfd_is_acc_op(i_cmd_op) && !t_flag) |=> !o_mem_we [*3])
    else $error("accumulator operation wrote memory outside index-memory mode");
  AST_POINTER_WRAP: assert property (@(posedge i_clk) disable iff (i_rst) // see RULE_13
    (state_reg == ST_HI_READ) |-> o_mem_re && (o_mem_addr[15:8] == addr_reg[15:8]))
    else $error("pointer high fetch left the page");
endmodule // csfd_core

// File: verif/csfd_mem_model.sv
// Byte memory model answering the core's memory port
`timescale 1ns/1ns
module csfd_mem_model (
  input wire logic i_clk,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic i_garble,
  output logic [7:0] o_rdata,
  output logic [15:0] o_rd_addr,
  output logic [15:0] o_wr_addr,
  output logic [15:0] o_wr_count
);
  logic [7:0] mem [0:65535];

  initial begin
    o_rdata = 8'h00;
    o_rd_addr = 16'h0000;
    o_wr_addr = 16'h0000;
    o_wr_count = 16'h0000;
  end

  // Read data stand one cycle only, then toggle every cycle so stale data match again only every second cycle
  always @(posedge i_clk) begin
    if (i_re) begin
      // Unreadable register hands back junk
      o_rdata <= i_garble ? 8'h5a : mem[i_addr];
      o_rd_addr <= i_addr;
    end else begin
      o_rdata <= ~o_rdata;
    end
    if (i_we) begin
      mem[i_addr] <= i_wdata;
      o_wr_addr <= i_addr;
      o_wr_count <= o_wr_count + 16'h0001;
    end
  end
endmodule // csfd_mem_model

// File: verif/cpu_status_flag_datapath_tb_top.sv
// Directed testbench for the status flag datapath core
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module cpu_status_flag_datapath_tb_top;
  import csfd_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_cmd_valid = 1'b0;
  csfd_op_t i_cmd_op = OP_CARRY_CLEAR;
  logic [15:0] i_cmd_addr = 16'h0000;
  logic [2:0] i_cmd_bit = 3'h0;
  logic [2:0] i_reg_addr = 3'h0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_we = 1'b0;
  logic i_reg_re = 1'b0;
  logic garble = 1'b0;
  logic o_cmd_ready, o_cmd_done, o_mem_we, o_mem_re;
  logic [15:0] o_mem_addr, o_jump_target, rd_addr, wr_addr, wr_count, n0;
  logic [7:0] o_mem_wdata, mem_rdata, o_reg_rdata, o_status, v, s0;
  int err_count = 0;
  int samples_checked = 0;
  logic [7:0] da [4] = '{8'h45, 8'h55, 8'h42, 8'h15};
  logic [7:0] dm [4] = '{8'h38, 8'h55, 8'h15, 8'h42};
  logic [7:0] dx [4] = '{8'h83, 8'h10, 8'h27, 8'h73};
  logic dxc [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  csfd_op_t tops [5] = '{OP_IOR, OP_CONJ, OP_XOR, OP_CARRY_ADD, OP_BORROW_SUB};
  logic [7:0] tm [5] = '{8'hf0, 8'hf0, 8'hf0, 8'h20, 8'h20};
  logic [7:0] tx [5] = '{8'hff, 8'h00, 8'hff, 8'h2f, 8'h10};
  csfd_op_t rops [10] = '{OP_BIT_CLEAR, OP_BIT_SET, OP_SHL, OP_SHR, OP_ROT_LEFT,
    OP_ROT_RIGHT, OP_NIB_ROT, OP_COUNT_UP, OP_COUNT_DOWN, OP_INVERT};
  logic [2:0] rbit [10] = '{3'h1, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  logic [7:0] rx [10] = '{8'h94, 8'h9e, 8'h2c, 8'h4b, 8'h2c, 8'h4b, 8'h69, 8'h97, 8'h95, 8'h69};

  always #4 i_clk = ~i_clk;

  csfd_core csfd_core_i (.i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
    .i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr), .i_cmd_bit(i_cmd_bit),
    .o_cmd_ready(o_cmd_ready), .o_cmd_done(o_cmd_done), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_mem_we(o_mem_we), .o_mem_re(o_mem_re),
    .i_mem_rdata(mem_rdata), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_we(i_reg_we), .i_reg_re(i_reg_re), .o_reg_rdata(o_reg_rdata),
    .o_status(o_status), .o_jump_target(o_jump_target));

  csfd_mem_model csfd_mem_model_i (.i_clk(i_clk), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata), .i_we(o_mem_we), .i_re(o_mem_re), .i_garble(garble),
    .o_rdata(mem_rdata), .o_rd_addr(rd_addr), .o_wr_addr(wr_addr), .o_wr_count(wr_count));

  task automatic poke(input logic [15:0] a, input logic [7:0] d);
    csfd_mem_model_i.mem[a] = d;
  endtask

  function automatic logic [7:0] peek(input logic [15:0] a);
    return csfd_mem_model_i.mem[a];
  endfunction

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_we <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_we <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_reg_re <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_re <= 1'b0;
    #1 d = o_reg_rdata;
  endtask

  // One command, then wait for its done pulse under a bound
  task automatic cmd(input csfd_op_t op, input logic [15:0] a = 16'h0000,
                     input logic [2:0] b = 3'h0);
    int n;
    n = 0;
    @(posedge i_clk);
    i_cmd_valid <= 1'b1;
    i_cmd_op <= op;
    i_cmd_addr <= a;
    i_cmd_bit <= b;
    @(posedge i_clk);
    i_cmd_valid <= 1'b0;
    while (o_cmd_done !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    `CHK(o_cmd_done, 1'b1)
  endtask

  task automatic do_reset();
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk);
    `CHK(o_status[PS_I], 1'b1)
    reg_rd(REG_STATUS, v);
    `CHK(v[PS_I], 1'b1)
  endtask

  task automatic conclude();
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    conclude();
  end

  initial begin
    do_reset();
    reg_wr(3'h5, 8'hff);
    reg_rd(3'h5, v);
    `CHK(v, 8'h00)
    // Decimal add and subtract, carry in and out
    cmd(OP_DEC_SET);
    for (int i = 0; i < 4; i++) begin
      poke(16'(16'h0300 + i), dm[i]);
      reg_wr(REG_ACC, da[i]);
      cmd(i < 2 ? OP_CARRY_CLEAR : OP_CARRY_SET);
      n0 = wr_count;
      cmd(i < 2 ? OP_CARRY_ADD : OP_BORROW_SUB, 16'(16'h0300 + i));
      reg_rd(REG_ACC, v);
      `CHK(v, dx[i])
      `CHK(o_status[PS_C], dxc[i])
      `CHK(wr_count, n0)
    end
    poke(16'h0310, 8'h09);
    cmd(OP_COUNT_UP, 16'h0310);
    `CHK(peek(16'h0310), 8'h0a)
    // Product and quotient with both mode flags set
    cmd(OP_XMODE_SET);
    cmd(OP_CARRY_SET);
    poke(16'h0400, 8'h34);
    poke(16'h0401, 8'h07);
    reg_wr(REG_ACC, 8'h12);
    s0 = o_status;
    n0 = wr_count;
    cmd(OP_PRODUCT, 16'h0400);
    reg_rd(REG_ACC, v);
    `CHK(v, 8'ha8)
    reg_rd(REG_INDEX_Y, v);
    `CHK(v, 8'h03)
    `CHK(o_status, s0)
    reg_wr(REG_ACC, 8'h64);
    cmd(OP_QUOTIENT, 16'h0401);
    reg_rd(REG_ACC, v);
    `CHK(v, 8'h0e)
    reg_rd(REG_INDEX_Y, v);
    `CHK(v, 8'h02)
    `CHK(o_status, s0)
    `CHK(wr_count, n0)
    // Accumulator operations on memory in index-memory mode
    cmd(OP_DEC_CLEAR);
    reg_wr(REG_ACC, 8'h0f);
    for (int i = 0; i < 5; i++) begin
      poke(16'(16'h0500 + i), tm[i]);
      cmd(OP_CARRY_CLEAR);
      cmd(tops[i], 16'(16'h0500 + i));
      `CHK(peek(16'(16'h0500 + i)), tx[i])
      `CHK(rd_addr, 16'(16'h0500 + i))
      `CHK(wr_addr, 16'(16'h0500 + i))
    end
    reg_rd(REG_ACC, v);
    `CHK(v, 8'h0f)
    cmd(OP_XMODE_CLEAR);
    // Binary add on the accumulator with decimal mode off
    poke(16'h0520, 8'h20);
    cmd(OP_CARRY_SET);
    cmd(OP_CARRY_ADD, 16'h0520);
    reg_rd(REG_ACC, v);
    `CHK(v, 8'h30)
    // Every read-modify-write kind on the same starting byte
    for (int i = 0; i < 10; i++) begin
      poke(16'(16'h0600 + i), 8'h96);
      cmd(OP_CARRY_CLEAR);
      n0 = wr_count;
      cmd(rops[i], 16'(16'h0600 + i), rbit[i]);
      `CHK(peek(16'(16'h0600 + i)), rx[i])
      `CHK(rd_addr, 16'(16'h0600 + i))
      `CHK(wr_addr, 16'(16'h0600 + i))
      `CHK(wr_count, 16'(n0 + 16'h0001))
    end
    // Junk read back from an unreadable place is still modified and written
    poke(16'h0700, 8'h00);
    garble <= 1'b1;
    cmd(OP_INVERT, 16'h0700);
    garble <= 1'b0;
    `CHK(peek(16'h0700), 8'ha5)
    for (int i = 0; i < 2; i++) begin
      cmd(OP_STATUS_PUSH);
      reg_rd(REG_STACK, v);
      `CHK(v, 8'(8'hfe - i))
      `CHK(peek({STACK_PAGE, 8'(v + 8'h01)}), o_status)
    end
    // Pointer on a page's last byte takes its high byte from the same page
    poke(16'h12ff, 8'h34);
    poke(16'h1200, 8'h56);
    poke(16'h1300, 8'h78);
    cmd(OP_JUMP_IND, 16'h12ff);
    `CHK(o_jump_target, 16'h5634)
    // Pointer placed away from the page end, as software is meant to
    poke(16'h1240, 8'hcd);
    poke(16'h1241, 8'hab);
    cmd(OP_JUMP_IND, 16'h1240);
    `CHK(o_jump_target, 16'habcd)
    cmd(OP_DEC_SET);
    do_reset();
    conclude();
  end
endmodule // cpu_status_flag_datapath_tb_top
